/* File: logic/mcg_clock_standby.sv */
// top: clock-gating and standby control for a dual-core processor subsystem
`timescale 1ns/100ps
module mcg_clock_standby
    import mcg_pkg::*;
#(
    parameter int NUM_CORES = 2
) (
    input  wire logic                 clk_i,           // processor clock
    input  wire logic                 rst_i,           // sync reset, high
    // system control coprocessor writes, per core
    input  wire logic [NUM_CORES-1:0] cop_wr_i,        // coproc write strobe
    input  wire logic [31:0]          cop_wdata_i,     // coproc write data
    // memory-mapped register port
    input  wire logic                 reg_wr_i,        // register write strobe
    input  wire logic                 reg_rd_i,        // register read strobe
    input  wire logic [35:0]          reg_addr_i,      // register address
    input  wire logic [31:0]          reg_wdata_i,     // write data
    output logic      [31:0]          reg_rdata_o,     // read data
    output logic                      reg_ack_o,       // access done
    output logic                      reg_err_o,       // unmapped address
    // core instruction events
    input  wire logic [NUM_CORES-1:0] wait_irq_i,      // wait-for-interrupt
    input  wire logic [NUM_CORES-1:0] wait_evt_i,      // wait-for-event
    input  wire logic [NUM_CORES-1:0] send_evt_i,      // send-event
    input  wire logic [NUM_CORES-1:0] irq_pin_i,       // irq, async pins
    // clock enables out to clock gates
    output logic      [NUM_CORES-1:0] core_clk_en_o,   // core clock run
    output logic                      irq_ctl_clk_en_o,// irq ctrl clock run
    output logic                      cu_clk_en_o,     // coherency unit run
    output logic                      cu_standby_o,    // coherency standby
    output logic                      l2_clk_en_o,     // cache clock run
    output logic                      l2_standby_ok_o, // cache may standby
    // secondary core boot
    output logic                      secondary_core_rst_o,  // held reset
    output logic      [31:0]          secondary_core_boot_address_o, // pc
    output logic      [NUM_CORES-1:0] core_wake_o      // wake pulses
);
    // ==========================================================
    // registers
    logic [31:0] core_pwr_r   [NUM_CORES];
    logic [31:0] core_pwr_nxt [NUM_CORES];
    logic [31:0] l2_power_control_r;
    logic [31:0] l2_power_control_nxt;
    logic [31:0] coherency_unit_control_r;
    logic [31:0] coherency_unit_control_nxt;
    logic [31:0] boot_addr_r;
    logic [31:0] boot_addr_nxt;
    logic        secondary_core_reset_bit_r;
    logic        secondary_core_reset_bit_nxt;
    logic [31:0] rdata_nxt;
    logic        ack_nxt;
    logic        err_nxt;
    logic [31:0] boot_pc_nxt;

    logic [NUM_CORES-1:0] irq_sync;
    logic [NUM_CORES-1:0] sleep;
    logic [NUM_CORES-1:0] hold;
    logic [NUM_CORES-1:0] core_gate_en;
    logic                 any_sleep;
    logic                 all_sleep;
    logic                 irq_pending;
    logic [31:0]          status_word;

    // ==========================================================
    // irq pins come from outside, two flops before use
    mcg_sync2 #(
        .WIDTH (NUM_CORES)
    ) u_irq_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (irq_pin_i),
        .q_o   (irq_sync)
    );

    // ==========================================================
    // per-core sleep trackers; send-event from any other running core wakes an event wait
    for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
        logic                 evt_other;
        logic [NUM_CORES-1:0] others;
        always_comb begin
            others    = send_evt_i & ~sleep & ~hold;
            others[c] = 1'b0;
            evt_other = |others;
        end

        // core 0 is never held; secondary cores follow reset bit
        assign hold[c] = (c == 0) ? 1'b0 : secondary_core_rst_o;

        mcg_core_sleep u_sleep (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .hold_i  (hold[c]),
            .wait_irq_i(wait_irq_i[c]),
            .wait_evt_i(wait_evt_i[c]),
            .event_i (evt_other),
            .irq_i   (irq_sync[c]),
            .sleep_o (sleep[c]),
            .wake_o  (core_wake_o[c])
        );

        // gating only if exact enable pattern is in the power word
        assign core_gate_en[c] = (core_pwr_r[c] == MCG_CORE_GATE_PATTERN);
        // a sleeping core with gating off keeps its clock
        assign core_clk_en_o[c] = ~(sleep[c] & core_gate_en[c]);
    end

    // ==========================================================
    // gating decisions; nothing stops until some core sleeps
    assign any_sleep   = |sleep;
    assign all_sleep   = &(sleep & core_gate_en);
    assign irq_pending = |irq_sync;

    // irq controller clock stops with nothing pending
    assign irq_ctl_clk_en_o =
        ~(coherency_unit_control_r[MCG_CU_IRQ_GATE_BIT] & any_sleep
          & ~irq_pending);

    // coherency unit standby once every core is gated
    assign cu_standby_o =
        coherency_unit_control_r[MCG_CU_STANDBY_BIT] & all_sleep;
    assign cu_clk_en_o = ~cu_standby_o;

    // cache controller: gating and standby permission
    assign l2_clk_en_o =
        ~(l2_power_control_r[MCG_L2_GATE_BIT] & all_sleep);
    assign l2_standby_ok_o =
        l2_power_control_r[MCG_L2_STANDBY_BIT] & any_sleep;

    // secondary core reset line straight from its register bit
    assign secondary_core_rst_o = secondary_core_reset_bit_r;

    // ==========================================================
    // status readback
    always_comb begin
        status_word = '0;
        status_word[NUM_CORES-1:0]         = sleep;
        status_word[8 +: NUM_CORES]        = core_clk_en_o;
        status_word[16]                    = cu_standby_o;
        status_word[17]                    = l2_clk_en_o;
        status_word[18]                    = irq_ctl_clk_en_o;
    end

    // ==========================================================
    // register writes, reads and coprocessor writes
    always_comb begin
        for (int i = 0; i < NUM_CORES; i++) begin
            core_pwr_nxt[i] = core_pwr_r[i];
            if (cop_wr_i[i]) begin
                core_pwr_nxt[i] = cop_wdata_i;
            end
        end
        l2_power_control_nxt         = l2_power_control_r;
        coherency_unit_control_nxt   = coherency_unit_control_r;
        boot_addr_nxt                = boot_addr_r;
        secondary_core_reset_bit_nxt = secondary_core_reset_bit_r;
        rdata_nxt = reg_rdata_o;
        ack_nxt   = reg_wr_i | reg_rd_i;
        err_nxt   = 1'b0;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                MCG_L2_POWER_CONTROL_ADDR:
                    l2_power_control_nxt = reg_wdata_i;
                MCG_COHERENCY_UNIT_CTRL_ADDR:
                    coherency_unit_control_nxt = reg_wdata_i;
                MCG_SECONDARY_BOOT_ADDR_ADDR:
                    boot_addr_nxt = reg_wdata_i;
                MCG_SECONDARY_RESET_ADDR:
                    secondary_core_reset_bit_nxt =
                        reg_wdata_i[MCG_SECONDARY_RESET_BIT];
                MCG_CORE_STATUS_ADDR: begin
                end
                default: err_nxt = 1'b1;
            endcase
        end else if (reg_rd_i) begin
            rdata_nxt = '0;
            unique case (reg_addr_i)
                MCG_L2_POWER_CONTROL_ADDR:    rdata_nxt = l2_power_control_r;
                MCG_COHERENCY_UNIT_CTRL_ADDR: rdata_nxt = coherency_unit_control_r;
                MCG_SECONDARY_BOOT_ADDR_ADDR: rdata_nxt = boot_addr_r;
                MCG_SECONDARY_RESET_ADDR:
                    rdata_nxt[MCG_SECONDARY_RESET_BIT] =
                        secondary_core_reset_bit_r;
                MCG_CORE_STATUS_ADDR:         rdata_nxt = status_word;
                default:                      err_nxt   = 1'b1;
            endcase
        end
    end

    // boot address latched while held so a late write cannot move pc
    always_comb begin
        boot_pc_nxt = secondary_core_boot_address_o;
        if (secondary_core_reset_bit_r) begin
            boot_pc_nxt = boot_addr_nxt;
        end
    end

    // ==========================================================
    // state registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_CORES; i++) begin
                core_pwr_r[i] <= MCG_CORE_PWR_RESET;
            end
            l2_power_control_r            <= MCG_L2_PWR_RESET;
            coherency_unit_control_r      <= MCG_CU_CTRL_RESET;
            boot_addr_r                   <= MCG_BOOT_ADDR_RESET;
            secondary_core_reset_bit_r    <= MCG_SECONDARY_RST_RESET;
            secondary_core_boot_address_o <= MCG_BOOT_ADDR_RESET;
            reg_rdata_o                   <= '0;
            reg_ack_o                     <= 1'b0;
            reg_err_o                     <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_CORES; i++) begin
                core_pwr_r[i] <= core_pwr_nxt[i];
            end
            l2_power_control_r            <= l2_power_control_nxt;
            coherency_unit_control_r      <= coherency_unit_control_nxt;
            boot_addr_r                   <= boot_addr_nxt;
            secondary_core_reset_bit_r    <= secondary_core_reset_bit_nxt;
            secondary_core_boot_address_o <= boot_pc_nxt;
            reg_rdata_o                   <= rdata_nxt;
            reg_ack_o                     <= ack_nxt;
            reg_err_o                     <= err_nxt;
        end
    end
endmodule

/* File: logic/mcg_core_sleep.sv */
// per-core standby tracker: wait-for-interrupt / wait-for-event and wakeup
`timescale 1ns/100ps
module mcg_core_sleep
    import mcg_pkg::*;
(
    input  wire logic clk_i,      // clock
    input  wire logic rst_i,      // sync reset
    input  wire logic hold_i,     // core held in reset
    input  wire logic wait_irq_i, // wait-for-interrupt executed, pulse
    input  wire logic wait_evt_i, // wait-for-event executed, pulse
    input  wire logic event_i,    // send-event from other core, pulse
    input  wire logic irq_i,      // interrupt request to core, level
    output logic      sleep_o,    // core is in standby
    output logic      wake_o      // wakeup pulse, one cycle
);
    mcg_core_state_t state_r;
    mcg_core_state_t state_nxt;
    logic            wake_nxt;

    // ==========================================================
    // sleep state; an interrupt also ends wait-for-event, as cores do
    always_comb begin
        state_nxt = state_r;
        wake_nxt  = 1'b0;
        unique case (state_r)
            MCG_RUN: begin
                if (wait_irq_i) begin
                    state_nxt = MCG_WAIT_IRQ;
                end else if (wait_evt_i) begin
                    state_nxt = MCG_WAIT_EVT;
                end
            end
            MCG_WAIT_IRQ: begin
                if (irq_i) begin
                    state_nxt = MCG_RUN;
                    wake_nxt  = 1'b1;
                end
            end
            MCG_WAIT_EVT: begin
                if (event_i || irq_i) begin
                    state_nxt = MCG_RUN;
                    wake_nxt  = 1'b1;
                end
            end
            default: begin
                state_nxt = MCG_RUN;
            end
        endcase
        // a core in reset is neither asleep nor running code
        if (hold_i) begin
            state_nxt = MCG_RUN;
            wake_nxt  = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= MCG_RUN;
            wake_o  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wake_o  <= wake_nxt;
        end
    end

    assign sleep_o = (state_r != MCG_RUN);
endmodule

/* File: logic/mcg_pkg.sv */
// package: register offsets, field positions and reset values for clock/standby control
//
// Function
// - each core has a power control word, written through the coprocessor port, that turns on its dynamic clock gating when the enable pattern is written.
// - with the interrupt-controller enable set, that controller's clock stops whenever no interrupt is pending.
// - with the coherency-unit standby enable set, the coherency unit enters standby once every core is clock-gated.
// - the cache controller gates its clock dynamically when the gating bit of its power control register is set.
// - the cache controller may enter standby when the standby bit of its power control register is set.
// - a core enters clock-gated standby when it executes a wait-for-interrupt or wait-for-event instruction.
// - no enabled gating mode takes effect until at least one core has entered standby.
// - a core in wait-for-event standby wakes when another running core executes a send-event instruction.
// - a core in wait-for-interrupt standby wakes when an interrupt request is asserted to it.
// - the secondary core is held in reset after boot until software releases it.
// - the secondary core starts fetching from the programmed boot address when it leaves reset.
// - clearing the secondary-core reset bit releases the secondary core from reset.
package mcg_pkg;

    // ==========================================================
    // register addresses
    localparam logic [35:0] MCG_L2_POWER_CONTROL_ADDR     = 36'h00ffffe80;
    localparam logic [35:0] MCG_COHERENCY_UNIT_CTRL_ADDR  = 36'hffffec000;
    localparam logic [35:0] MCG_SECONDARY_BOOT_ADDR_ADDR  = 36'h000000010;
    localparam logic [35:0] MCG_SECONDARY_RESET_ADDR      = 36'h000000014;
    localparam logic [35:0] MCG_CORE_STATUS_ADDR          = 36'h000000018;

    // ==========================================================
    // field positions
    localparam int MCG_CU_IRQ_GATE_BIT     = 6;
    localparam int MCG_CU_STANDBY_BIT      = 5;
    localparam int MCG_L2_GATE_BIT         = 1;
    localparam int MCG_L2_STANDBY_BIT      = 0;
    localparam int MCG_SECONDARY_RESET_BIT = 0;

    // ==========================================================
    // values
    localparam logic [31:0] MCG_CORE_GATE_PATTERN   = 32'h0000_0701;
    localparam logic [31:0] MCG_CORE_PWR_RESET      = 32'h0000_0000;
    localparam logic [31:0] MCG_L2_PWR_RESET        = 32'h0000_0000;
    localparam logic [31:0] MCG_CU_CTRL_RESET       = 32'h0000_0000;
    localparam logic [31:0] MCG_BOOT_ADDR_RESET     = 32'h0000_0000;
    localparam logic        MCG_SECONDARY_RST_RESET = 1'b1;

    // core sleep states, one-hot
    typedef enum logic [2:0] {
        MCG_RUN      = 3'b001,
        MCG_WAIT_IRQ = 3'b010,
        MCG_WAIT_EVT = 3'b100
    } mcg_core_state_t;

endpackage

/* File: logic/mcg_sync2.sv */
// two-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
module mcg_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,  // clock
    input  wire logic             rst_i,  // sync reset
    input  wire logic [WIDTH-1:0] d_i,    // async level
    output logic      [WIDTH-1:0] q_o     // synchronised level
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_nxt;

    // ==========================================================
    // next values: first stage only feeds second stage
    always_comb begin
        meta_nxt = d_i;
        q_nxt    = meta_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_o    <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_o    <= q_nxt;
        end
    end
endmodule

/* File: sim/mcg_clock_standby_properties.sv */
// checker: timing relations at the clock and standby control ports
`timescale 1ns/100ps
module mcg_clock_standby_properties
    import mcg_pkg::*;
#(
    parameter int NUM_CORES = 2
) (
    input  wire logic                 clk_i,          // clock
    input  wire logic                 rst_i,          // sync reset
    input  wire logic [NUM_CORES-1:0] cop_wr_i,       // power word write
    input  wire logic                 reg_wr_i,       // register write
    input  wire logic [35:0]          reg_addr_i,     // register address
    input  wire logic [31:0]          reg_wdata_i,    // write data
    input  wire logic [NUM_CORES-1:0] wait_irq_i,     // wait for irq
    input  wire logic [NUM_CORES-1:0] wait_evt_i,     // wait for event
    input  wire logic [NUM_CORES-1:0] send_evt_i,     // send event
    input  wire logic [NUM_CORES-1:0] irq_pin_i,      // irq pins
    input  wire logic [NUM_CORES-1:0] core_clk_en_o,  // core clock run
    input  wire logic                 irq_ctl_clk_en_o, // irq ctl run
    input  wire logic                 cu_standby_o,   // coherency standby
    input  wire logic                 l2_clk_en_o,    // cache clock run
    input  wire logic                 secondary_core_rst_o, // held
    input  wire logic [31:0]          secondary_core_boot_address_o, // pc
    input  wire logic [NUM_CORES-1:0] core_wake_o     // wake pulses
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ==========================================================
    // steps: event sleep, then a send-event from the other core
    sequence evt_sleep_s;
        wait_evt_i[0] && !wait_irq_i[0] && core_clk_en_o[0]
        ##1 !core_clk_en_o[0] && send_evt_i[1] && core_clk_en_o[1]
            && !secondary_core_rst_o;
    endsequence
    sequence irq_rise_s;
        !core_clk_en_o[0] && $rose(irq_pin_i[0]);
    endsequence

    // ==========================================================
    // properties
    core_gate_a: assert property ($fell(core_clk_en_o[0])
        |-> $past(wait_irq_i[0] || wait_evt_i[0] || cop_wr_i[0]))
        else $error("core clock stopped without a wait");
    gate_after_sleep_a: assert property (!l2_clk_en_o
        |-> !(&core_clk_en_o)) else $error("cache gated, no core asleep");
    cu_standby_a: assert property (cu_standby_o
        |-> ~|core_clk_en_o) else $error("standby while a core runs");
    event_wake_a: assert property (evt_sleep_s
        |=> core_clk_en_o[0] && core_wake_o[0])
        else $error("send-event did not wake the core");
    irq_wake_a: assert property (irq_rise_s
        |-> ##[1:5] core_wake_o[0]) else $error("irq did not wake core");
    irq_clock_a: assert property (irq_pin_i[0] [*4]
        |-> irq_ctl_clk_en_o) else $error("irq ctl clock off, irq pending");
    held_core_a: assert property (secondary_core_rst_o
        && (wait_irq_i[1] || wait_evt_i[1]) |=> core_clk_en_o[1])
        else $error("held core went to sleep");
    release_a: assert property ($fell(secondary_core_rst_o)
        |-> $past(reg_wr_i && reg_addr_i == MCG_SECONDARY_RESET_ADDR
        && !reg_wdata_i[MCG_SECONDARY_RESET_BIT]))
        else $error("secondary released without a write");
    boot_stable_a: assert property (!secondary_core_rst_o
        |-> $stable(secondary_core_boot_address_o))
        else $error("boot address moved after release");
endmodule
bind mcg_clock_standby mcg_clock_standby_properties #(
    .NUM_CORES(NUM_CORES)
) mcg_clock_standby_properties_i (
    .clk_i(clk_i), .rst_i(rst_i), .cop_wr_i(cop_wr_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .wait_irq_i(wait_irq_i),
    .wait_evt_i(wait_evt_i), .send_evt_i(send_evt_i),
    .irq_pin_i(irq_pin_i), .core_clk_en_o(core_clk_en_o),
    .irq_ctl_clk_en_o(irq_ctl_clk_en_o), .cu_standby_o(cu_standby_o),
    .l2_clk_en_o(l2_clk_en_o), .secondary_core_rst_o(secondary_core_rst_o),
    .secondary_core_boot_address_o(secondary_core_boot_address_o),
    .core_wake_o(core_wake_o));

/* File: sim/mcg_clock_standby_test.sv */
// testbench: clock and standby control against a behavioural model
`timescale 1ns/100ps
module mcg_clock_standby_test;
    import mcg_pkg::*;
    logic        clk_i, rst_i, reg_wr_i, reg_rd_i, reg_ack_o, reg_err_o;
    logic        irq_ctl_clk_en_o, cu_standby_o, l2_clk_en_o, cu_clk_en_o;
    logic        l2_standby_ok_o, secondary_core_rst_o, er;
    logic [1:0]  cop_wr_i, wait_irq_i, wait_evt_i, send_evt_i, irq_pin_i;
    logic [1:0]  core_clk_en_o, core_wake_o, m_sleep;
    logic [35:0] reg_addr_i;
    logic [31:0] cop_wdata_i, reg_wdata_i, reg_rdata_o, rd, boot, m_cu, m_l2;
    logic [31:0] secondary_core_boot_address_o;
    logic [31:0] m_pw [2];
    int          n_mismatch = 0, comparisons = 0, cycles = 0;

    mcg_clock_standby #(.NUM_CORES(2)) mcg_clock_standby_i (
        .clk_i(clk_i), .rst_i(rst_i), .cop_wr_i(cop_wr_i),
        .cop_wdata_i(cop_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
        .reg_err_o(reg_err_o), .wait_irq_i(wait_irq_i),
        .wait_evt_i(wait_evt_i), .send_evt_i(send_evt_i),
        .irq_pin_i(irq_pin_i), .core_clk_en_o(core_clk_en_o),
        .irq_ctl_clk_en_o(irq_ctl_clk_en_o), .cu_clk_en_o(cu_clk_en_o),
        .cu_standby_o(cu_standby_o),
        .l2_clk_en_o(l2_clk_en_o), .l2_standby_ok_o(l2_standby_ok_o),
        .secondary_core_rst_o(secondary_core_rst_o),
        .secondary_core_boot_address_o(secondary_core_boot_address_o),
        .core_wake_o(core_wake_o));
    mcg_core_model mcg_core_model_i (.clk_i(clk_i),
        .wait_irq_o(wait_irq_i), .wait_evt_o(wait_evt_i),
        .send_evt_o(send_evt_i), .irq_o(irq_pin_i));

    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // strobe for one edge, answer sampled half a cycle after it
    task automatic acc(input logic wr, input logic [35:0] a,
                       input logic [31:0] d);
        @(negedge clk_i);
        reg_wr_i = wr;
        reg_rd_i = !wr;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        check(reg_ack_o, 1'b1);
        rd = reg_rdata_o;
        er = reg_err_o;
    endtask
    // expected enables, worked out from the model state alone
    task automatic check_outs;
        logic [1:0] g;
        g[0] = m_sleep[0] && m_pw[0] == MCG_CORE_GATE_PATTERN;
        g[1] = m_sleep[1] && m_pw[1] == MCG_CORE_GATE_PATTERN;
        check(core_clk_en_o, {30'h0, ~g});
        check(irq_ctl_clk_en_o, !(m_cu[6] && |m_sleep));
        check(cu_standby_o, m_cu[MCG_CU_STANDBY_BIT] && &g);
        check(cu_clk_en_o, !(m_cu[MCG_CU_STANDBY_BIT] && &g));
        check(l2_clk_en_o, !(m_l2[1] && &g));
        check(l2_standby_ok_o, m_l2[0] && |m_sleep);
    endtask
    // bounded wait for the wake pulse of the sleeping cores
    task automatic wait_wake(input logic [1:0] m);
        int k;
        k = 0;
        while (core_wake_o !== m && k < 10) begin
            @(negedge clk_i);
            k++;
        end
        check(core_wake_o, m);
        m_sleep = m_sleep & ~m;
        mcg_core_model_i.button(2'b00);
        repeat (4) @(negedge clk_i);
        check_outs;
    endtask
    task automatic end_of_test;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==========================================================
    // clock, hang limit and main sequence
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // the whole run needs under a hundred cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            end_of_test;
        end
    end
    initial begin
        {rst_i, cop_wr_i, cop_wdata_i, reg_wr_i, reg_rd_i} = {1'b1, 36'h0};
        {reg_addr_i, reg_wdata_i, m_cu, m_l2, m_sleep} = '0;
        m_pw[0] = 32'h0;
        m_pw[1] = 32'h0;
        rd = $urandom(32'h4a59);
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        // reset values and an unmapped address
        check_outs;
        check(secondary_core_rst_o, 1'b1);
        acc(1'b0, MCG_L2_POWER_CONTROL_ADDR, 32'h0);
        check(rd, MCG_L2_PWR_RESET);
        acc(1'b0, MCG_COHERENCY_UNIT_CTRL_ADDR, 32'h0);
        check(rd, MCG_CU_CTRL_RESET);
        acc(1'b0, 36'h000000020, 32'h0);
        check(er, 1'b1);
        // sleep with every enable clear, woken by a button
        mcg_core_model_i.step(2'b01, 2'b00, 2'b00);
        mcg_core_model_i.step(2'b00, 2'b00, 2'b00);
        m_sleep = 2'b01;
        check_outs;
        mcg_core_model_i.button(2'b01);
        wait_wake(2'b01);
        // all enables before any sleep, random spare bits
        m_cu = ($urandom & 32'hffff_ff9f) | 32'h0000_0060;
        m_l2 = ($urandom & 32'hffff_fffc) | 32'h0000_0003;
        acc(1'b1, MCG_COHERENCY_UNIT_CTRL_ADDR, m_cu);
        acc(1'b1, MCG_L2_POWER_CONTROL_ADDR, m_l2);
        acc(1'b0, MCG_COHERENCY_UNIT_CTRL_ADDR, 32'h0);
        check(rd, m_cu);
        acc(1'b0, MCG_L2_POWER_CONTROL_ADDR, 32'h0);
        check(rd, m_l2);
        @(negedge clk_i);
        cop_wr_i = 2'b11;
        cop_wdata_i = MCG_CORE_GATE_PATTERN;
        @(negedge clk_i);
        cop_wr_i = 2'b00;
        m_pw[0] = MCG_CORE_GATE_PATTERN;
        m_pw[1] = MCG_CORE_GATE_PATTERN;
        check_outs;
        // held secondary ignores a wait, then boots at a random address
        mcg_core_model_i.step(2'b10, 2'b00, 2'b00);
        mcg_core_model_i.step(2'b00, 2'b00, 2'b00);
        check(core_clk_en_o, 32'h3);
        boot = $urandom;
        acc(1'b1, MCG_SECONDARY_BOOT_ADDR_ADDR, boot);
        acc(1'b1, MCG_SECONDARY_RESET_ADDR, 32'h0);
        check(secondary_core_rst_o, 1'b0);
        check(secondary_core_boot_address_o, boot);
        acc(1'b0, MCG_SECONDARY_RESET_ADDR, 32'h0);
        check(rd, 32'h0);
        // event sleep, send-event from the other core at once
        mcg_core_model_i.step(2'b00, 2'b01, 2'b00);
        mcg_core_model_i.step(2'b00, 2'b00, 2'b10);
        m_sleep = 2'b01;
        check_outs;
        mcg_core_model_i.step(2'b00, 2'b00, 2'b00);
        check(core_wake_o, 32'h1);
        m_sleep = 2'b00;
        check_outs;
        // both cores asleep, then both woken by interrupts
        mcg_core_model_i.step(2'b11, 2'b00, 2'b00);
        mcg_core_model_i.step(2'b00, 2'b00, 2'b00);
        m_sleep = 2'b11;
        check_outs;
        // a send-event from a sleeping core wakes nobody
        mcg_core_model_i.step(2'b00, 2'b00, 2'b01);
        mcg_core_model_i.step(2'b00, 2'b00, 2'b00);
        check_outs;
        // status: both asleep, standby on, cache and irq clocks off
        acc(1'b0, MCG_CORE_STATUS_ADDR, 32'h0);
        check(rd, 32'h0001_0003);
        mcg_core_model_i.button(2'b11);
        wait_wake(2'b11);
        end_of_test;
    end
endmodule

/* File: sim/mcg_core_model.sv */
// partner: instruction and interrupt events issued by the two cores
`timescale 1ns/100ps
module mcg_core_model (
    input  wire logic       clk_i,       // clock
    output logic      [1:0] wait_irq_o,  // wait-for-interrupt pulses
    output logic      [1:0] wait_evt_o,  // wait-for-event pulses
    output logic      [1:0] send_evt_o,  // send-event pulses
    output logic      [1:0] irq_o        // button-like irq levels
);
    // idle at time zero so nothing is taken during reset
    initial begin
        wait_irq_o = 2'h0;
        wait_evt_o = 2'h0;
        send_evt_o = 2'h0;
        irq_o      = 2'h0;
    end
    // one instruction cycle per call, changed away from the sampling edge
    task automatic step(input logic [1:0] wi, input logic [1:0] we,
                        input logic [1:0] se);
        @(negedge clk_i);
        wait_irq_o = wi;
        wait_evt_o = we;
        send_evt_o = se;
    endtask
    // level held until the next call, like a pressed button
    task automatic button(input logic [1:0] lv);
        @(negedge clk_i);
        irq_o = lv;
    endtask
endmodule
